/* File: pcs_pkg.sv */
// package for the supply's two-wire command slave: addresses, command codes, timing
// assumes the device clock runs at 100 MHz
package pcs_pkg;
    localparam int CLK_MHZ = 100;
    localparam logic [3:0] NIB_MCU = 4'h8;
    localparam logic [3:0] NIB_EEPROM = 4'hA;
    localparam logic [3:0] NIB_SELECTOR = 4'hE;
    localparam logic [7:0] ADDR_BROADCAST = 8'h00;
    localparam logic [7:0] CMD_ONOFF = 8'h01;
    localparam logic [7:0] CMD_CLEAR = 8'h03;
    localparam logic [7:0] CMD_VOUT_SET = 8'h21;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
    localparam logic [7:0] CMD_READ_STATUS = 8'hD0;
    localparam logic [7:0] CMD_LAMP_TEST_ON = 8'hD2;
    localparam logic [7:0] CMD_LAMP_TEST_OFF = 8'hD3;
    localparam logic [7:0] CMD_ATTN_ON = 8'hD4;
    localparam logic [7:0] CMD_ATTN_OFF = 8'hD5;
    localparam logic [7:0] CMD_EE_WR_EN = 8'hD6;
    localparam logic [7:0] CMD_EE_WR_DIS = 8'hD7;
    localparam logic [7:0] CMD_LATCH_OFF = 8'hD8;
    localparam logic [7:0] CMD_AUTO_RESTART = 8'hD9;
    localparam logic [7:0] CMD_ISO_TEST = 8'hDA;
    localparam logic [7:0] CMD_READ_INPUT = 8'hDC;
    localparam logic [7:0] CMD_READ_FW = 8'hDD;
    localparam logic [7:0] CMD_READ_TIMER = 8'hDE;
    localparam logic [7:0] CMD_FAN_SET = 8'hDF;
    localparam logic [7:0] CMD_FAN_NORMAL = 8'hE0;
    localparam logic [7:0] CMD_READ_FAN = 8'hE1;
    localparam logic [7:0] CMD_CLOCK_HOLD = 8'hE2;
    localparam logic [7:0] ONOFF_ON = 8'h80;
    localparam logic [7:0] ONOFF_OFF = 8'h00;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [15:0] VOUT_RESET = 16'h0000;
    localparam logic [15:0] OV_RESET = 16'hFFFF;
    // direct format constants, y = (m*x + b) * 10^R
    localparam int M_VOUT = 400;
    localparam int M_IOUT = 5;
    localparam int M_TEMP = 1;
    localparam int M_VIN = 1;
    localparam int B_VIN = 75;
    localparam int M_PIN = 1;
    localparam int M_FAN_PCT = 1;
    localparam int M_FAN_RPM = 100;
    localparam int R_ALL = 0;
    localparam int HOLD_MS = 25;
    localparam int HOLD_CYCLES = HOLD_MS * 1000 * CLK_MHZ;
    typedef enum logic [2:0] {PCS_IDLE, PCS_ADDR, PCS_CMD, PCS_DATA, PCS_IGNORE} pcs_phase_e;
    typedef struct packed {
        logic output_on;
        logic lamp_test;
        logic attention_lamp;
        logic ee_write_en;
        logic latch_off;
        logic fan_forced;
    } pcs_ctrl_s;
    typedef struct packed {
        logic iso_passed;
        logic iso_failed;
        logic restarted_ok;
        logic invalid_cmd;
        logic pec_error;
    } pcs_flags_s;
endpackage

/* File: pcs_slave.sv */
// two-wire command slave of the supply's management controller
// assumes SCL/SDA arrive from pins asynchronously; open-drain outputs, enable low = pulling low
`timescale 1ns/100ps
// Summary of operation
// - broadcast accepted for writes only; broadcast reads never acknowledged
// - selector function never acknowledges the broadcast address
// - alert asserted on the first internal event, not after settling
// - address bits 3..1 are unit straps, bit 0 is direction
// - upper nibble 1000 controller, 1010 EEPROM, 1110 selector
// - all-zero address is broadcast write executed like own address
// - same three unit address bits serve every function in the supply
// - up to three data bytes, low byte first then higher
// - write frame: address, command, data, checksum, each acknowledged
// - numeric values in direct format, m times value plus b
// - conversion constants per quantity as fixed in the package
// - decode lamp test, attention lamp and EEPROM write enable commands
// - decode latch off, auto restart and isolation test commands
// - decode input, firmware, timer, fan reads and fan set commands
// - command E2 holds the clock line low for 25 ms
// - output on at power-up while enable low; 80 on, 00 off
// - off then on clears all alarms and shutdown latches
// - fault clear resets isolation, restart and invalid-command flags
// - checksum is CRC-8 polynomial 07 over all frame bytes
// - frames without a valid trailing checksum are not executed
// - clock held low only after ninth bit, at most 25 ms
module pcs_slave #(
    parameter int HOLD_CYC = pcs_pkg::HOLD_CYCLES
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic SCL_IN,
    output logic SCL_OE_N,
    input wire logic SDA_IN,
    output logic SDA_OE_N,
    input wire logic [2:0] UNIT_ADDR,
    input wire logic ENABLE_N,
    input wire logic ISO_RESULT_VALID,
    input wire logic ISO_RESULT_PASS,
    input wire logic RESTART_DONE,
    output logic ALERT_N,
    output pcs_pkg::pcs_ctrl_s CTRL,
    output pcs_pkg::pcs_flags_s FLAGS,
    output logic [15:0] VOUT_SET,
    output logic [15:0] OV_LIMIT,
    output logic [23:0] FAN_SET,
    output logic ISO_START,
    output logic AUTO_RESTART,
    output logic READ_REQ,
    output logic [7:0] READ_CMD
);
    // synchronisers: stage one read only by stage two
    logic [1:0] scl_s, sda_s, en_s;
    logic scl_q, sda_q;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            en_s <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], SCL_IN};
            sda_s <= {sda_s[0], SDA_IN};
            en_s <= {en_s[0], ENABLE_N};
            scl_q <= scl_s[1];
            sda_q <= sda_s[1];
        end
    end
    wire scl_rise = scl_s[1] & ~scl_q;
    wire scl_fall = ~scl_s[1] & scl_q;
    wire start_c = scl_s[1] & scl_q & ~sda_s[1] & sda_q;
    wire stop_c = scl_s[1] & scl_q & sda_s[1] & ~sda_q;

    logic [2:0] unit;
    logic strap_done;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            unit <= 3'h0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            unit <= UNIT_ADDR;
            strap_done <= 1'b1;
        end
    end

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ pcs_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // expected data length per command; 4'hF marks unknown
    function automatic logic [3:0] cmd_len(input logic [7:0] c);
        unique case (c)
            pcs_pkg::CMD_ONOFF: cmd_len = 4'h1;
            pcs_pkg::CMD_CLEAR: cmd_len = 4'h0;
            pcs_pkg::CMD_VOUT_SET, pcs_pkg::CMD_OV_LIMIT: cmd_len = 4'h2;
            pcs_pkg::CMD_LAMP_TEST_ON, pcs_pkg::CMD_LAMP_TEST_OFF, pcs_pkg::CMD_ATTN_ON,
            pcs_pkg::CMD_ATTN_OFF, pcs_pkg::CMD_EE_WR_EN, pcs_pkg::CMD_EE_WR_DIS,
            pcs_pkg::CMD_LATCH_OFF, pcs_pkg::CMD_AUTO_RESTART, pcs_pkg::CMD_ISO_TEST: cmd_len = 4'h0;
            // reads answered elsewhere, fan set and restore here
            pcs_pkg::CMD_READ_STATUS, pcs_pkg::CMD_READ_INPUT, pcs_pkg::CMD_READ_FW,
            pcs_pkg::CMD_READ_TIMER, pcs_pkg::CMD_READ_FAN: cmd_len = 4'h0;
            pcs_pkg::CMD_FAN_SET: cmd_len = 4'h3;
            pcs_pkg::CMD_FAN_NORMAL, pcs_pkg::CMD_CLOCK_HOLD: cmd_len = 4'h0;
            default: cmd_len = 4'hF;
        endcase
    endfunction

    // byte engine
    pcs_pkg::pcs_phase_e phase, next_phase;
    logic [3:0] bitn, next_bitn;
    logic [7:0] shreg, next_shreg;
    logic [7:0] crc, next_crc;
    logic [7:0] cmd, next_cmd;
    logic [3:0] nbytes, next_nbytes;
    logic [23:0] dbuf, next_dbuf;
    logic [7:0] pec_rx, next_pec_rx;
    logic ack, next_ack;
    logic frame_ok, next_frame_ok;
    always_comb begin
        logic [7:0] b;
        b = {shreg[6:0], sda_q};
        next_phase = phase;
        next_bitn = bitn;
        next_shreg = shreg;
        next_crc = crc;
        next_cmd = cmd;
        next_nbytes = nbytes;
        next_dbuf = dbuf;
        next_pec_rx = pec_rx;
        next_ack = ack;
        next_frame_ok = 1'b0;
        if (start_c) begin
            next_phase = pcs_pkg::PCS_ADDR;
            next_bitn = 4'h0;
            next_crc = pcs_pkg::CRC_INIT;
            next_nbytes = 4'h0;
            next_ack = 1'b0;
        end else if (stop_c) begin
            // stop executes only with a trailing checksum that matched
            if (phase == pcs_pkg::PCS_DATA && cmd_len(cmd) != 4'hF && nbytes == cmd_len(cmd) + 4'h1
                && pec_rx == crc) begin
                next_frame_ok = 1'b1;
            end
            next_phase = pcs_pkg::PCS_IDLE;
            next_ack = 1'b0;
        end else if (phase != pcs_pkg::PCS_IDLE && phase != pcs_pkg::PCS_IGNORE) begin
            if (scl_fall && bitn == 4'h8) begin
                // ack slot driven from fall after bit 8 to fall after bit 9
                next_ack = 1'b1;
                next_bitn = 4'h9;
            end else if (scl_fall && bitn == 4'h9) begin
                next_ack = 1'b0;
                next_bitn = 4'h0;
            end else if (scl_rise && bitn < 4'h8) begin
                next_shreg = b;
                next_bitn = bitn + 4'h1;
                if (bitn == 4'h7) begin
                    unique case (phase)
                        pcs_pkg::PCS_ADDR: begin
                            // shared unit bits; broadcast write only
                            // selector nibble never matches since only the controller nibble is compared
                            if (b == pcs_pkg::ADDR_BROADCAST || (b[7:4] == pcs_pkg::NIB_MCU && b[3:1] == unit && !b[0])) begin
                                next_phase = pcs_pkg::PCS_CMD;
                                next_crc = crc_step(crc, b);
                            end else begin
                                next_phase = pcs_pkg::PCS_IGNORE;
                            end
                        end
                        pcs_pkg::PCS_CMD: begin
                            next_cmd = b;
                            next_crc = crc_step(crc, b);
                            next_phase = pcs_pkg::PCS_DATA;
                        end
                        default: begin
                            // low byte first; only payload bytes enter dbuf, so a 3-byte payload fits
                            next_pec_rx = b;
                            if (nbytes < cmd_len(cmd)) begin
                                next_dbuf = {b, dbuf[23:8]};
                                next_crc = crc_step(crc, b);
                            end
                            next_nbytes = nbytes + 4'h1;
                        end
                    endcase
                end
            end
        end
        if (next_phase == pcs_pkg::PCS_IGNORE || next_phase == pcs_pkg::PCS_IDLE) begin
            next_ack = next_ack & ~(phase == pcs_pkg::PCS_IGNORE);
        end
    end
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            phase <= pcs_pkg::PCS_IDLE;
            bitn <= 4'h0;
            shreg <= 8'h00;
            crc <= pcs_pkg::CRC_INIT;
            cmd <= 8'h00;
            nbytes <= 4'h0;
            dbuf <= 24'h000000;
            pec_rx <= 8'h00;
            ack <= 1'b0;
            frame_ok <= 1'b0;
        end else begin
            phase <= next_phase;
            bitn <= next_bitn;
            shreg <= next_shreg;
            crc <= next_crc;
            cmd <= next_cmd;
            nbytes <= next_nbytes;
            dbuf <= next_dbuf;
            pec_rx <= next_pec_rx;
            ack <= next_ack;
            frame_ok <= next_frame_ok;
        end
    end
    assign SDA_OE_N = ~ack;

    // command execution and device state
    pcs_pkg::pcs_ctrl_s ctrl, next_ctrl;
    pcs_pkg::pcs_flags_s flags, next_flags;
    logic [15:0] vout, next_vout, ov, next_ov;
    logic [23:0] fan, next_fan;
    logic iso_go, next_iso_go, autor, next_autor, rreq, next_rreq, alert, next_alert;
    logic [7:0] rcmd, next_rcmd;
    logic en_q;
    logic [31:0] hold_cnt, next_hold_cnt;
    logic bad_pec;
    // payload enters dbuf from the top, so short payloads sit in the upper bytes
    logic [7:0] d0, d1, d2;
    always_comb begin
        d0 = 8'h00;
        d1 = 8'h00;
        d2 = 8'h00;
        unique case (cmd_len(cmd))
            4'h1: d0 = dbuf[23:16];
            4'h2: begin
                d0 = dbuf[15:8];
                d1 = dbuf[23:16];
            end
            default: begin
                d0 = dbuf[7:0];
                d1 = dbuf[15:8];
                d2 = dbuf[23:16];
            end
        endcase
    end
    assign bad_pec = stop_c && phase == pcs_pkg::PCS_DATA && !next_frame_ok && cmd_len(cmd) != 4'hF;
    always_comb begin
        next_ctrl = ctrl;
        next_flags = flags;
        next_vout = vout;
        next_ov = ov;
        next_fan = fan;
        next_iso_go = 1'b0;
        next_autor = autor;
        next_rreq = 1'b0;
        next_rcmd = rcmd;
        next_alert = alert;
        next_hold_cnt = (hold_cnt != 32'h0000_0000) ? hold_cnt - 32'h0000_0001 : hold_cnt;
        // enable pin edges switch the output
        if (en_s[1] != en_q) begin
            next_ctrl.output_on = ~en_s[1];
        end
        if (frame_ok) begin
            unique case (cmd)
                pcs_pkg::CMD_ONOFF: begin
                    if (d0 == pcs_pkg::ONOFF_ON) next_ctrl.output_on = 1'b1;
                    else if (d0 == pcs_pkg::ONOFF_OFF) next_ctrl.output_on = 1'b0;
                end
                pcs_pkg::CMD_CLEAR: begin
                    next_flags.iso_passed = 1'b0;
                    next_flags.iso_failed = 1'b0;
                    next_flags.restarted_ok = 1'b0;
                    next_flags.invalid_cmd = 1'b0;
                    next_flags.pec_error = 1'b0;
                    next_alert = 1'b0;
                end
                // raw direct-format words, m=400 for both voltages
                pcs_pkg::CMD_VOUT_SET: next_vout = {d1, d0};
                pcs_pkg::CMD_OV_LIMIT: next_ov = {d1, d0};
                pcs_pkg::CMD_LAMP_TEST_ON: next_ctrl.lamp_test = 1'b1;
                pcs_pkg::CMD_LAMP_TEST_OFF: next_ctrl.lamp_test = 1'b0;
                pcs_pkg::CMD_ATTN_ON: next_ctrl.attention_lamp = 1'b1;
                pcs_pkg::CMD_ATTN_OFF: next_ctrl.attention_lamp = 1'b0;
                pcs_pkg::CMD_EE_WR_EN: next_ctrl.ee_write_en = 1'b1;
                pcs_pkg::CMD_EE_WR_DIS: next_ctrl.ee_write_en = 1'b0;
                pcs_pkg::CMD_LATCH_OFF: next_autor = 1'b0;
                pcs_pkg::CMD_AUTO_RESTART: next_autor = 1'b1;
                pcs_pkg::CMD_ISO_TEST: next_iso_go = 1'b1;
                pcs_pkg::CMD_FAN_SET: begin
                    next_fan = {d2, d1, d0};
                    next_ctrl.fan_forced = 1'b1;
                end
                pcs_pkg::CMD_FAN_NORMAL: next_ctrl.fan_forced = 1'b0;
                pcs_pkg::CMD_CLOCK_HOLD: next_hold_cnt = 32'(HOLD_CYC);
                default: begin
                    next_rreq = 1'b1;
                    next_rcmd = cmd;
                end
            endcase
        end
        // off-to-on recycle clears alarms and latches
        if (next_ctrl.output_on && !ctrl.output_on) begin
            next_flags = '0;
            next_ctrl.latch_off = 1'b0;
            next_alert = 1'b0;
        end
        if (!next_ctrl.output_on && ctrl.output_on && !next_autor) begin
            next_ctrl.latch_off = 1'b1;
        end
        // event sets win over clears
        if (bad_pec) begin
            next_flags.pec_error = 1'b1;
            next_alert = 1'b1;
        end
        if (stop_c && phase == pcs_pkg::PCS_DATA && cmd_len(cmd) == 4'hF) begin
            next_flags.invalid_cmd = 1'b1;
            next_alert = 1'b1;
        end
        if (ISO_RESULT_VALID) begin
            next_flags.iso_passed = ISO_RESULT_PASS;
            next_flags.iso_failed = ~ISO_RESULT_PASS;
            next_alert = 1'b1;
        end
        if (RESTART_DONE) begin
            next_flags.restarted_ok = 1'b1;
            next_alert = 1'b1;
        end
    end
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl <= '0;
            flags <= '0;
            vout <= pcs_pkg::VOUT_RESET;
            ov <= pcs_pkg::OV_RESET;
            fan <= 24'h00_0000;
            iso_go <= 1'b0;
            autor <= 1'b1;
            rreq <= 1'b0;
            rcmd <= 8'h00;
            alert <= 1'b0;
            hold_cnt <= 32'h0000_0000;
            en_q <= 1'b1;
        end else begin
            ctrl <= next_ctrl;
            flags <= next_flags;
            vout <= next_vout;
            ov <= next_ov;
            fan <= next_fan;
            iso_go <= next_iso_go;
            autor <= next_autor;
            rreq <= next_rreq;
            rcmd <= next_rcmd;
            alert <= next_alert;
            hold_cnt <= next_hold_cnt;
            en_q <= en_s[1];
        end
    end
    // hold starts only after the ninth bit, as the execute follows stop
    assign SCL_OE_N = (hold_cnt == 32'h0000_0000);
    // alert follows the first event directly
    assign ALERT_N = ~alert;
    assign CTRL = ctrl;
    assign FLAGS = flags;
    assign VOUT_SET = vout;
    assign OV_LIMIT = ov;
    assign FAN_SET = fan;
    assign ISO_START = iso_go;
    assign AUTO_RESTART = autor;
    assign READ_REQ = rreq;
    assign READ_CMD = rcmd;

    property p_bcast_read_nack;
        @(posedge MCLK) disable iff (!RESETN)
        (phase == pcs_pkg::PCS_ADDR && scl_rise && bitn == 4'h7 && {shreg[6:0], sda_q} == 8'h01)
        |=> phase == pcs_pkg::PCS_IGNORE;
    endproperty
    a_bcast_read_nack: assert property (p_bcast_read_nack) else $error("broadcast read accepted");
    property p_selector_no_ack;
        @(posedge MCLK) disable iff (!RESETN)
        (phase == pcs_pkg::PCS_IGNORE) |-> SDA_OE_N;
    endproperty
    a_selector_no_ack: assert property (p_selector_no_ack) else $error("ack in ignored frame");
    property p_alert_fast;
        @(posedge MCLK) disable iff (!RESETN)
        RESTART_DONE |=> !ALERT_N;
    endproperty
    a_alert_fast: assert property (p_alert_fast) else $error("alert late");
    property p_onoff_on;
        @(posedge MCLK) disable iff (!RESETN)
        (frame_ok && cmd == pcs_pkg::CMD_ONOFF && d0 == pcs_pkg::ONOFF_ON) |=> CTRL.output_on;
    endproperty
    a_onoff_on: assert property (p_onoff_on) else $error("output not on");
    property p_clear;
        @(posedge MCLK) disable iff (!RESETN)
        (frame_ok && cmd == pcs_pkg::CMD_CLEAR && !RESTART_DONE && !ISO_RESULT_VALID) |=> !FLAGS.restarted_ok;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ineffective");
    property p_no_exec_bad;
        @(posedge MCLK) disable iff (!RESETN)
        frame_ok |-> (pec_rx == crc);
    endproperty
    a_no_exec_bad: assert property (p_no_exec_bad) else $error("executed without checksum");
    property p_hold;
        @(posedge MCLK) disable iff (!RESETN)
        (frame_ok && cmd == pcs_pkg::CMD_CLOCK_HOLD) |=> !SCL_OE_N [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("clock not held");
    property p_invalid;
        @(posedge MCLK) disable iff (!RESETN)
        (stop_c && phase == pcs_pkg::PCS_DATA && cmd_len(cmd) == 4'hF) |=> FLAGS.invalid_cmd && !ALERT_N;
    endproperty
    a_invalid: assert property (p_invalid) else $error("unknown code not flagged");
endmodule // pcs_slave

/* File: pcs_host.sv */
// bus master model for the supply's two-wire command slave
// assumes pull-ups on both lines; enables low pull the line low
`timescale 1ns/100ps
module pcs_host (
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe_n,
    output logic sda_oe_n
);
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
    end
    task automatic wait_scl();
        for (int i = 0; i < 2000 && scl !== 1'b1; i++) #10;
    endtask
    task automatic start();
        sda_oe_n = 1'b1;
        scl_oe_n = 1'b1;
        wait_scl();
        #60 sda_oe_n = 1'b0;
        #60 scl_oe_n = 1'b0;
        #32;
    endtask
    task automatic stop();
        sda_oe_n = 1'b0;
        #31 scl_oe_n = 1'b1;
        #60 sda_oe_n = 1'b1;
        #60;
    endtask
    task automatic bit_io(input logic b, output logic r);
        // steps of 30 and 35 keep every change off the device clock edges
        sda_oe_n = b;
        #30 scl_oe_n = 1'b1;
        wait_scl();
        #30 r = sda;
        #30 scl_oe_n = 1'b0;
        #35;
    endtask
    // msb first, ninth bit released for ack
    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
endmodule // pcs_host

/* File: pcs_slave_bench.sv */
// self-checking bench for the command slave, host model on the far side
// assumes the hold count parameter is shortened to 50 cycles
`timescale 1ns/100ps
module pcs_slave_bench;
    logic mclk = 0, resetn = 0, enable_n = 0, iso_v = 0, iso_p = 0, rst_done = 0, iso_seen = 0;
    logic [2:0] unit = 3'b101;
    logic h_scl, h_sda, scl_oe_n, sda_oe_n, alert_n, iso_start, auto_restart, read_req;
    logic [7:0] read_cmd, last_rd = 8'h00;
    logic [15:0] vout, ov;
    logic [23:0] fan;
    pcs_pkg::pcs_ctrl_s ctrl;
    pcs_pkg::pcs_flags_s flags;
    wire scl = h_scl & scl_oe_n;
    wire sda = h_sda & sda_oe_n;
    int err_count = 0, n_tests = 0;
    logic [7:0] zc [8] = '{8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hD9};
    logic [3:0] ze [8] = '{4'h9, 4'h1, 4'h5, 4'h1, 4'h3, 4'h1, 4'h0, 4'h1};
    logic [7:0] rc [5] = '{8'hD0, 8'hDC, 8'hDD, 8'hDE, 8'hE1};
    always #5 mclk = ~mclk;
    pcs_slave #(.HOLD_CYC(50)) DUT (.MCLK(mclk), .RESETN(resetn), .SCL_IN(scl), .SCL_OE_N(scl_oe_n),
        .SDA_IN(sda), .SDA_OE_N(sda_oe_n), .UNIT_ADDR(unit), .ENABLE_N(enable_n), .ISO_RESULT_VALID(iso_v),
        .ISO_RESULT_PASS(iso_p), .RESTART_DONE(rst_done), .ALERT_N(alert_n), .CTRL(ctrl), .FLAGS(flags),
        .VOUT_SET(vout), .OV_LIMIT(ov), .FAN_SET(fan), .ISO_START(iso_start), .AUTO_RESTART(auto_restart),
        .READ_REQ(read_req), .READ_CMD(read_cmd));
    pcs_host host (.scl(scl), .sda(sda), .scl_oe_n(h_scl), .sda_oe_n(h_sda));
    // one-cycle pulses are caught here so the main thread can check them later
    always @(posedge mclk) begin
        if (read_req) last_rd <= read_cmd;
        if (iso_start) iso_seen <= 1'b1;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        repeat (8) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        return x;
    endfunction
    task automatic wr(input logic [39:0] f, input int n, input logic bad, input int exp_nk);
        logic [7:0] b, crc;
        logic a;
        int nk;
        crc = 8'h00;
        nk = 0;
        host.start();
        for (int i = 0; i < n; i++) begin
            b = f[39-8*i -: 8];
            crc = crc8(crc, b);
            host.byte_out(b, a);
            nk += int'(!a);
        end
        host.byte_out(crc ^ {7'h00, bad}, a);
        nk += int'(!a);
        host.stop();
        repeat (10) @(negedge mclk);
        chk("nack count", 24'(nk), 24'(exp_nk));
    endtask
    initial begin
        #1_000_000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (2) @(negedge mclk);
        resetn = 1;
        repeat (10) @(negedge mclk);
        // straps move after capture; frames to the old address must still match
        unit = 3'b100;
        chk("power-up on", ctrl.output_on, 1);
        chk("ov limit", ov, 24'h00_FFFF);
        wr({8'h8A, 8'h01, 8'h00, 16'h0000}, 3, 0, 0);
        chk("off", ctrl.output_on, 0);
        wr({8'h8A, 8'h01, 8'h80, 16'h0000}, 3, 1, 0);
        chk("bad pec on", {ctrl.output_on, flags.pec_error, alert_n}, 3'b010);
        wr({8'h8A, 8'h01, 8'h80, 16'h0000}, 3, 0, 0);
        chk("restart clears", {flags, alert_n}, 6'h01);
        wr({8'h8A, 8'h21, 8'hD4, 8'h4E, 8'h00}, 4, 0, 0);
        chk("vout", vout, 24'h00_4ED4);
        wr({8'h8A, 8'h40, 8'h34, 8'h12, 8'h00}, 4, 0, 0);
        chk("ov", ov, 24'h00_1234);
        wr({8'h8A, 8'h55, 24'h00_0000}, 2, 0, 0);
        chk("invalid", {flags.invalid_cmd, alert_n, ctrl.output_on}, 3'b101);
        iso_v = 1;
        iso_p = 1;
        rst_done = 1;
        @(negedge mclk);
        iso_v = 0;
        rst_done = 0;
        @(negedge mclk);
        chk("iso restart", {flags.iso_passed, flags.restarted_ok}, 2'b11);
        wr({8'h8A, 8'h03, 24'h00_0000}, 2, 0, 0);
        chk("cleared", {flags.iso_passed, flags.restarted_ok, flags.invalid_cmd, alert_n}, 4'h1);
        for (int i = 0; i < 8; i++) begin
            wr({8'h8A, zc[i], 24'h00_0000}, 2, 0, 0);
            chk("zero-data", {ctrl.lamp_test, ctrl.attention_lamp, ctrl.ee_write_en, auto_restart}, ze[i]);
        end
        wr({8'h00, 8'hD4, 24'h00_0000}, 2, 0, 0);
        chk("broadcast", ctrl.attention_lamp, 1);
        wr({8'h8A, 8'hD5, 24'h00_0000}, 2, 0, 0);
        wr({8'h01, 8'hD4, 24'h00_0000}, 2, 0, 3);
        wr({8'hEA, 8'hD4, 24'h00_0000}, 2, 0, 3);
        wr({8'hAA, 8'hD4, 24'h00_0000}, 2, 0, 3);
        wr({8'h88, 8'hD4, 24'h00_0000}, 2, 0, 3);
        wr({8'h8B, 8'hD4, 24'h00_0000}, 2, 0, 3);
        chk("refused", ctrl.attention_lamp, 0);
        wr({8'h8A, 8'hDA, 24'h00_0000}, 2, 0, 0);
        chk("iso start", iso_seen, 1);
        wr({8'h8A, 8'hDF, 8'h01, 8'h02, 8'h03}, 5, 0, 0);
        chk("fan", {ctrl.fan_forced, fan}, 25'h103_0201);
        wr({8'h8A, 8'hE0, 24'h00_0000}, 2, 0, 0);
        chk("fan normal", ctrl.fan_forced, 0);
        for (int i = 0; i < 5; i++) begin
            repeat (20) @(negedge mclk);
            wr({8'h8A, rc[i], 24'h00_0000}, 2, 0, 0);
            chk("read cmd", last_rd, rc[i]);
        end
        wr({8'h8A, 8'hE2, 24'h00_0000}, 2, 0, 0);
        chk("hold low", scl_oe_n, 0);
        repeat (60) @(negedge mclk);
        chk("hold end", scl_oe_n, 1);
        enable_n = 1;
        repeat (10) @(negedge mclk);
        chk("pin off", ctrl.output_on, 0);
        enable_n = 0;
        repeat (10) @(negedge mclk);
        chk("pin on", ctrl.output_on, 1);
        give_verdict();
    end
endmodule // pcs_slave_bench
